// ===== design/tx_inject_defs.svh
// register map, field positions, reset values and timing for transmit injection
`ifndef TX_INJECT_DEFS_SVH
`define TX_INJECT_DEFS_SVH

// =====================================================================
// control bus addresses
`define TXI_ADDR_W 5
`define TXI_ADDR_TSR 5'h04
`define TXI_ADDR_THR 5'h05
`define TXI_ADDR_SYM1 5'h06
`define TXI_ADDR_CNT 5'h1E

// =====================================================================
// transmit state register fields
`define TXI_TM_HI 2
`define TXI_TM_LO 0
`define TXI_IC_HI 4
`define TXI_IC_LO 3
`define TXI_IC0_BIT 3
`define TXI_SE_BIT 5
`define TXI_REQUEST_PARITY_ON_BIT 6
`define TXI_RES_BIT 7

// =====================================================================
// reset values
`define TXI_TSR_RST 8'h82
`define TXI_THR_RST 8'h00
`define TXI_SYM1_RST 8'h00
`define TXI_CNT_RST 8'h00
`define TXI_ZERO8 8'h00
`define TXI_ONE8 8'h01
`define TXI_SYM_HI 4
`define TXI_SYM_LO 0

// =====================================================================
// symbol pair time against the 25 ns clock, rounded up
`define TXI_PAIR_NS 80
`define TXI_CLK_NS 25
`define TXI_PAIR_CYCLES ((`TXI_PAIR_NS + `TXI_CLK_NS - 1) / `TXI_CLK_NS)
`define TXI_DIV_W 3

`endif

// ===== design/tx_inject_pkg.sv
// shared types for the transmit injection block
`default_nettype none

package tx_inject_pkg;

  // injection control field codes, in field order
  typedef enum logic [1:0] {
    INJ_NONE,
    INJ_ONE_SHOT,
    INJ_PERIODIC,
    INJ_CONT
  } inj_mode_t;

  // one shot sequencing
  typedef enum logic [1:0] {
    OS_WAIT_JK,
    OS_COUNT,
    OS_DUE
  } os_state_t;

  // control bus request
  typedef struct packed {
    logic sel;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cb_req_t;

  // pair arriving from smoother, repeat filter, encoder and mode logic
  typedef struct packed {
    logic [4:0] sym_a;
    logic [4:0] sym_b;
    logic is_jk;
    logic is_data;
    logic [7:0] req_byte;
    logic req_par;
  } req_pair_t;

  // pair leaving toward the PMD transmitter
  typedef struct packed {
    logic [4:0] sym_a;
    logic [4:0] sym_b;
    logic injected;
  } sym_pair_t;

endpackage

`default_nettype wire

// ===== design/pair_buffer.sv
// two-entry valid/ready buffer on the outgoing symbol pair path
`default_nettype none

module pair_buffer #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  // =====================================================================
  // handshake
  assign in_ready = (count_ff != CW'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // storage, one flop row per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_ff[i] <= '0;
      end else if (push && (wr_ptr_ff == PW'(i))) begin
        mem_ff[i] <= in_data;
      end
    end
  end

  // pointers wrap at depth
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
      end
    end
  end

  // fill level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + CW'(1);
    end else if (pop && !push) begin
      count_ff <= count_ff - CW'(1);
    end
  end

endmodule

`default_nettype wire

// ===== design/tx_symbol_injection.sv
// transmit symbol injection: counter, injection pair, smoother and parity controls
// =====================================================================
`include "tx_inject_defs.svh"
`default_nettype none

module tx_symbol_injection
  import tx_inject_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire cb_req_t cb_req,
  output logic [7:0] cb_rdata,
  input wire logic in_valid,
  input wire req_pair_t in_pair,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output sym_pair_t out_pair,
  input wire logic [4:0] injection_symbol_second,
  output logic [2:0] transmit_mode,
  output logic smoother_on,
  output logic [7:0] smooth_count,
  output logic request_parity_on,
  output logic parity_error
);

  logic [7:0] transmit_state_reg_ff;
  logic [7:0] injection_threshold_ff;
  logic [7:0] injection_symbol_first_ff;
  logic [7:0] injection_count_now_ff;
  logic [`TXI_DIV_W-1:0] div_ff;
  os_state_t os_state_ff;
  logic smooth_run_ff;
  logic [7:0] smooth_count_ff;
  logic parity_error_ff;
  logic [7:0] cb_rdata_ff;
  inj_mode_t injection_control;
  logic tick;
  logic take;
  logic cnt_run;
  logic cnt_zero;
  logic inject;
  logic inj_fire;
  logic tsr_wr;
  logic thr_wr;
  logic sym1_wr;
  logic buf_in_ready;
  sym_pair_t buf_in_data;

  // =====================================================================
  // decode and field views
  assign tsr_wr = cb_req.sel && cb_req.wr && (cb_req.addr == `TXI_ADDR_TSR);
  assign thr_wr = cb_req.sel && cb_req.wr && (cb_req.addr == `TXI_ADDR_THR);
  assign sym1_wr = cb_req.sel && cb_req.wr && (cb_req.addr == `TXI_ADDR_SYM1);
  assign injection_control =
    inj_mode_t'(transmit_state_reg_ff[`TXI_IC_HI:`TXI_IC_LO]);
  assign transmit_mode = transmit_state_reg_ff[`TXI_TM_HI:`TXI_TM_LO];
  assign smoother_on = transmit_state_reg_ff[`TXI_SE_BIT];
  assign request_parity_on = transmit_state_reg_ff[`TXI_REQUEST_PARITY_ON_BIT];
  assign cnt_run = (injection_control == INJ_ONE_SHOT) ||
                   (injection_control == INJ_PERIODIC);
  assign cnt_zero = (injection_count_now_ff == `TXI_ZERO8);

  // =====================================================================
  // symbol pair time divider
  assign tick = (div_ff == `TXI_DIV_W'(`TXI_PAIR_CYCLES - 1));

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else begin
      div_ff <= tick ? '0 : div_ff + `TXI_DIV_W'(1);
    end
  end

  // one pair slot per tick, held off while the buffer is full
  assign in_ready = tick && buf_in_ready;
  assign take = in_ready && in_valid;

  // =====================================================================
  // injection decision per mode
  always_comb begin
    inject = 1'b0;
    case (injection_control)
      INJ_ONE_SHOT: begin
        case (os_state_ff)
          OS_WAIT_JK: begin
            inject = in_pair.is_jk &&
                     (injection_threshold_ff == `TXI_ZERO8);
          end
          OS_COUNT: begin
            inject = cnt_zero && in_pair.is_data;
          end
          OS_DUE: begin
            inject = in_pair.is_data;
          end
          default: begin
            inject = 1'b0;
          end
        endcase
      end
      INJ_PERIODIC: begin
        inject = cnt_zero && in_pair.is_data;
      end
      INJ_CONT: begin
        inject = in_pair.is_data;
      end
      default: begin
        inject = 1'b0;
      end
    endcase
  end

  assign inj_fire = take && inject;

  // one shot sequencing: wait for JK, count, fire once
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      os_state_ff <= OS_WAIT_JK;
    end else if (injection_control != INJ_ONE_SHOT) begin
      os_state_ff <= OS_WAIT_JK;
    end else begin
      case (os_state_ff)
        OS_WAIT_JK: begin
          if (take && in_pair.is_jk && !inj_fire) begin
            os_state_ff <= OS_COUNT;
          end
        end
        OS_COUNT: begin
          if (inj_fire) begin
            os_state_ff <= OS_WAIT_JK;
          end else if (tick && cnt_zero) begin
            os_state_ff <= OS_DUE;
          end
        end
        OS_DUE: begin
          if (inj_fire) begin
            os_state_ff <= OS_WAIT_JK;
          end
        end
        default: begin
          os_state_ff <= OS_WAIT_JK;
        end
      endcase
    end
  end

  // =====================================================================
  // injection down-counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      injection_count_now_ff <= `TXI_CNT_RST;
    end else if (thr_wr) begin
      injection_count_now_ff <= cb_req.wdata;
    end else if (tick && cnt_run) begin
      if (injection_control == INJ_ONE_SHOT && os_state_ff == OS_WAIT_JK &&
          take && in_pair.is_jk) begin
        injection_count_now_ff <= injection_threshold_ff;
      end else if (cnt_zero) begin
        injection_count_now_ff <= injection_threshold_ff;
      end else begin
        injection_count_now_ff <= injection_count_now_ff - `TXI_ONE8;
      end
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      transmit_state_reg_ff <= `TXI_TSR_RST;
    end else if (tsr_wr) begin
      transmit_state_reg_ff <= cb_req.wdata;
    end else if (inj_fire && injection_control == INJ_ONE_SHOT) begin
      transmit_state_reg_ff[`TXI_IC0_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      injection_threshold_ff <= `TXI_THR_RST;
    end else if (thr_wr) begin
      injection_threshold_ff <= cb_req.wdata;
    end
  end

  // upper bits stored for readback only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      injection_symbol_first_ff <= `TXI_SYM1_RST;
    end else if (sym1_wr) begin
      injection_symbol_first_ff <= cb_req.wdata;
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cb_rdata_ff <= `TXI_ZERO8;
    end else if (cb_req.sel && !cb_req.wr) begin
      if (cb_req.addr == `TXI_ADDR_TSR) begin
        cb_rdata_ff <= transmit_state_reg_ff;
      end else if (cb_req.addr == `TXI_ADDR_THR) begin
        cb_rdata_ff <= injection_threshold_ff;
      end else if (cb_req.addr == `TXI_ADDR_SYM1) begin
        cb_rdata_ff <= injection_symbol_first_ff;
      end else if (cb_req.addr == `TXI_ADDR_CNT) begin
        cb_rdata_ff <= injection_count_now_ff;
      end else begin
        cb_rdata_ff <= `TXI_ZERO8;
      end
    end
  end

  assign cb_rdata = cb_rdata_ff;

  // =====================================================================
  // smoother counter: JK restarts it, otherwise it runs on
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smooth_run_ff <= 1'b0;
      smooth_count_ff <= `TXI_ZERO8;
    end else if (!smoother_on) begin
      smooth_run_ff <= 1'b0;
      smooth_count_ff <= `TXI_ZERO8;
    end else if (take && in_pair.is_jk) begin
      smooth_run_ff <= 1'b1;
      smooth_count_ff <= `TXI_ZERO8;
    end else if (tick && smooth_run_ff) begin
      smooth_count_ff <= smooth_count_ff + `TXI_ONE8;
    end
  end

  assign smooth_count = smooth_count_ff;

  // request parity, odd over byte and parity bit
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parity_error_ff <= 1'b0;
    end else begin
      parity_error_ff <= take && request_parity_on &&
                         !(^{in_pair.req_byte, in_pair.req_par});
    end
  end

  assign parity_error = parity_error_ff;

  // =====================================================================
  // output mux: programmed 5B pair overrides the incoming pair
  always_comb begin
    if (inj_fire) begin
      buf_in_data.sym_a =
        injection_symbol_first_ff[`TXI_SYM_HI:`TXI_SYM_LO];
      buf_in_data.sym_b = injection_symbol_second;
      buf_in_data.injected = 1'b1;
    end else begin
      buf_in_data.sym_a = in_pair.sym_a;
      buf_in_data.sym_b = in_pair.sym_b;
      buf_in_data.injected = 1'b0;
    end
  end

  pair_buffer #(
    .WIDTH($bits(sym_pair_t)),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(tick && in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_pair)
  );

  // =====================================================================
  // assertions
  property p_smooth_off;
    @(posedge ref_clk) disable iff (sys_rst)
    !smoother_on |=> (smooth_count == `TXI_ZERO8);
  endproperty
  a_smooth_off: assert property (p_smooth_off)
    else $error("smoother count not cleared while disabled");

  property p_smooth_jk;
    @(posedge ref_clk) disable iff (sys_rst)
    smoother_on && take && in_pair.is_jk && !tsr_wr |=>
      (smooth_count == `TXI_ZERO8) ##[3:4]
      (smooth_count == `TXI_ONE8 || !smoother_on || $past(take && in_pair.is_jk));
  endproperty
  a_smooth_jk: assert property (p_smooth_jk)
    else $error("smoother count not restarted by JK");

  property p_parity_off;
    @(posedge ref_clk) disable iff (sys_rst)
    take && !request_parity_on |=> !parity_error;
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("parity error flagged while parity disabled");

  property p_res_bit;
    @(posedge ref_clk)
    $fell(sys_rst) |-> transmit_state_reg_ff[`TXI_RES_BIT] && cnt_zero;
  endproperty
  a_res_bit: assert property (p_res_bit)
    else $error("reset values wrong");

  property p_thr_reload;
    @(posedge ref_clk) disable iff (sys_rst)
    thr_wr |=> (injection_count_now_ff == $past(cb_req.wdata));
  endproperty
  a_thr_reload: assert property (p_thr_reload)
    else $error("counter not reloaded on threshold write");

  property p_decrement;
    @(posedge ref_clk) disable iff (sys_rst)
    tick && cnt_run && !thr_wr && !cnt_zero && !(take && in_pair.is_jk) |=>
      (injection_count_now_ff == $past(injection_count_now_ff) - `TXI_ONE8);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not decrement on pair tick");

  property p_idle;
    @(posedge ref_clk) disable iff (sys_rst)
    !cnt_run && !thr_wr |=> $stable(injection_count_now_ff);
  endproperty
  a_idle: assert property (p_idle)
    else $error("counter moved outside counting modes");

  property p_periodic;
    @(posedge ref_clk) disable iff (sys_rst)
    take && injection_control == INJ_PERIODIC && cnt_zero && in_pair.is_data
      |-> inj_fire;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic injection missed at zero count");

  property p_os_jk;
    @(posedge ref_clk) disable iff (sys_rst)
    take && injection_control == INJ_ONE_SHOT && os_state_ff == OS_WAIT_JK &&
      in_pair.is_jk && injection_threshold_ff == `TXI_ZERO8 |-> inj_fire;
  endproperty
  a_os_jk: assert property (p_os_jk)
    else $error("JK not replaced with zero threshold");

  property p_cont;
    @(posedge ref_clk) disable iff (sys_rst)
    take && injection_control == INJ_CONT && in_pair.is_data |-> inj_fire;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous mode left a data pair");

  property p_ic0_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    inj_fire && injection_control == INJ_ONE_SHOT && !tsr_wr |=>
      !transmit_state_reg_ff[`TXI_IC0_BIT] ##1 (injection_control == INJ_NONE
      || tsr_wr || $past(tsr_wr));
  endproperty
  a_ic0_clear: assert property (p_ic0_clear)
    else $error("one shot did not clear its control bit");

  property p_payload;
    @(posedge ref_clk) disable iff (sys_rst)
    inj_fire |-> buf_in_data.injected &&
      buf_in_data.sym_a == injection_symbol_first_ff[`TXI_SYM_HI:`TXI_SYM_LO] &&
      buf_in_data.sym_b == injection_symbol_second;
  endproperty
  a_payload: assert property (p_payload)
    else $error("injected pair not the programmed symbols");

endmodule

`default_nettype wire

// ===== testbench/pmd_sink.sv
// model of the PMD transmitter that takes the outgoing symbol pairs
`default_nettype none

module pmd_sink
  import tx_inject_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic out_valid,
  input wire sym_pair_t out_pair,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  sym_pair_t got[$];

  // =====================================================================
  // ready moves off the sampling edge; low while stalled or in reset
  always @(negedge ref_clk) begin
    out_ready <= !stall && !sys_rst;
  end

  // record every accepted pair in arrival order
  always @(posedge ref_clk) begin
    if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back(out_pair);
    end
  end
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the transmit symbol injection block
`include "tx_inject_defs.svh"
`default_nettype none

module testbench
  import tx_inject_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam req_pair_t JK = '{5'h18, 5'h11, 1'b1, 1'b0, 8'h00, 1'b1};
  logic ref_clk, sys_rst, in_valid, stall, in_ready, out_valid, out_ready;
  logic smoother_on, request_parity_on, parity_error;
  logic [7:0] cb_rdata, smooth_count, rd, rd2;
  logic [2:0] transmit_mode;
  logic [4:0] inj_second, sym1;
  logic [15:0] injm;
  cb_req_t cb_req;
  req_pair_t in_pair, bad;
  sym_pair_t out_pair;
  int mismatches, num_checks, hi;

  // =====================================================================
  // design and transmitter model
  tx_symbol_injection tx_symbol_injection_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cb_req(cb_req), .cb_rdata(cb_rdata),
    .in_valid(in_valid), .in_pair(in_pair), .in_ready(in_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_pair(out_pair),
    .injection_symbol_second(inj_second), .transmit_mode(transmit_mode),
    .smoother_on(smoother_on), .smooth_count(smooth_count),
    .request_parity_on(request_parity_on), .parity_error(parity_error));
  pmd_sink pmd_sink_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall),
    .out_valid(out_valid), .out_pair(out_pair), .out_ready(out_ready));

  // =====================================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    results();
  end

  // =====================================================================
  // reporting
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // =====================================================================
  // control bus: one request cycle, read data sampled a cycle later
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cb_req = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(negedge ref_clk);
    cb_req.sel = 1'b0;
    rd = cb_rdata;
  endtask
  task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, {8'h00, rd}, {8'h00, exp});
  endtask

  // =====================================================================
  // pair stream: hold the offer until a tick takes it
  function automatic req_pair_t dp(input logic [7:0] k);
    return '{5'h15, k[4:0], 1'b0, 1'b1, k, ~^k};
  endfunction
  task automatic send(input req_pair_t p);
    int i;
    @(negedge ref_clk);
    in_pair = p;
    in_valid = 1'b1;
    for (i = 0; i < 40 && in_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40) begin
      mismatches++;
      results();
    end
    @(posedge ref_clk);
    // offer withdrawn once taken, so no later tick repeats it
    @(negedge ref_clk);
    in_valid = 1'b0;
  endtask
  // drain the buffer, compare passed pairs against the offered ones and injected pairs against the programmed symbols
  task automatic judge(input int n, input int jk);
    @(negedge ref_clk);
    in_valid = 1'b0;
    repeat (16) @(negedge ref_clk);
    injm = '0;
    hi = 0;
    foreach (pmd_sink_i.got[j]) begin
      req_pair_t o;
      sym_pair_t g;
      o = (jk != 0 && j == 0) ? JK : dp(8'(j + 1 - jk));
      g = pmd_sink_i.got[j];
      injm[j] = g.injected;
      if (g.injected === 1'b1) begin
        hi++;
        chk("injected pair", {6'h00, g.sym_a, g.sym_b}, {6'h00, sym1, inj_second});
      end else begin
        chk("passed pair", {6'h00, g.sym_a, g.sym_b}, {6'h00, o.sym_a, o.sym_b});
      end
    end
    chk("pair count", 16'(pmd_sink_i.got.size()), 16'(n + jk));
  endtask
  task automatic run(input int n, input int jk);
    pmd_sink_i.got.delete();
    if (jk != 0) send(JK);
    for (int k = 1; k <= n; k++) send(dp(8'(k)));
    judge(n, jk);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    stall = 1'b0;
    in_valid = 1'b0;
    in_pair = '0;
    cb_req = '0;
    inj_second = 5'h0D;
    sym1 = 5'h00;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    rchk("state reg", `TXI_ADDR_TSR, 8'h82);
    rchk("threshold", `TXI_ADDR_THR, 8'h00);
    rchk("first symbol", `TXI_ADDR_SYM1, 8'h00);
    rchk("count", `TXI_ADDR_CNT, 8'h00);
    rchk("unmapped", 5'h10, 8'h00);
    chk("mode out", {13'h0, transmit_mode}, 16'h0002);
    // idle counter loads on threshold write and then stands
    bus(1'b1, `TXI_ADDR_TSR, 8'h00);
    bus(1'b1, `TXI_ADDR_THR, 8'hA5);
    rchk("threshold rw", `TXI_ADDR_THR, 8'hA5);
    rchk("count load", `TXI_ADDR_CNT, 8'hA5);
    repeat (12) @(negedge ref_clk);
    rchk("count idle", `TXI_ADDR_CNT, 8'hA5);
    bus(1'b1, `TXI_ADDR_SYM1, 8'hE9);
    sym1 = 5'h09;
    rchk("first symbol rw", `TXI_ADDR_SYM1, 8'hE9);
    run(4, 1);
    chk("none mode", injm, 16'h0000);
    // full buffer refuses while the transmitter stalls
    pmd_sink_i.got.delete();
    @(posedge ref_clk);
    stall = 1'b1;
    send(dp(8'd1));
    send(dp(8'd2));
    hi = 0;
    repeat (12) begin
      @(negedge ref_clk);
      hi += int'(in_ready !== 1'b0);
    end
    chk("full refuse", 16'(hi), 16'h0000);
    stall = 1'b0;
    send(dp(8'd3));
    judge(3, 0);
    // smoother and parity controls
    bus(1'b1, `TXI_ADDR_TSR, 8'h60);
    rchk("state rw", `TXI_ADDR_TSR, 8'h60);
    chk("smoother on", {15'h0, smoother_on}, 16'h0001);
    chk("parity on", {15'h0, request_parity_on}, 16'h0001);
    send(JK);
    rd2 = smooth_count;
    repeat (8) @(negedge ref_clk);
    chk("smooth run", {8'h00, smooth_count}, {8'h00, rd2 + 8'd2});
    send(JK);
    #1 chk("smooth jk", {8'h00, smooth_count}, 16'h0000);
    bad = dp(8'h3C);
    bad.req_par = ~bad.req_par;
    send(bad);
    #1 chk("parity flag", {15'h0, parity_error}, 16'h0001);
    bus(1'b1, `TXI_ADDR_TSR, 8'h20);
    send(bad);
    #1 chk("parity off", {15'h0, parity_error}, 16'h0000);
    bus(1'b1, `TXI_ADDR_TSR, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("smoother off", {7'h0, smoother_on, smooth_count}, 16'h0000);
    pmd_sink_i.got.delete();
    judge(0, 0);
    // counter steps once per pair time
    bus(1'b1, `TXI_ADDR_THR, 8'hC8);
    bus(1'b1, `TXI_ADDR_TSR, 8'h10);
    bus(1'b0, `TXI_ADDR_CNT, 8'h00);
    rd2 = rd;
    repeat (6) @(negedge ref_clk);
    rchk("count step", `TXI_ADDR_CNT, rd2 - 8'd2);
    // periodic, threshold two and zero
    bus(1'b1, `TXI_ADDR_THR, 8'h02);
    run(12, 0);
    chk("periodic n", 16'(hi), 16'h0004);
    bus(1'b1, `TXI_ADDR_THR, 8'h00);
    run(6, 0);
    chk("periodic zero", injm, 16'h003F);
    // continuous
    bus(1'b1, `TXI_ADDR_TSR, 8'h18);
    run(5, 1);
    chk("continuous", injm, 16'h003E);
    // one shot, threshold zero then three
    bus(1'b1, `TXI_ADDR_TSR, 8'h08);
    run(3, 1);
    chk("one shot jk", injm, 16'h0001);
    rchk("one shot done", `TXI_ADDR_TSR, 8'h00);
    bus(1'b1, `TXI_ADDR_THR, 8'h03);
    bus(1'b1, `TXI_ADDR_TSR, 8'h08);
    run(8, 1);
    chk("one shot n", injm, 16'h0010);
    rchk("one shot clear", `TXI_ADDR_TSR, 8'h00);
    results();
  end
endmodule

`default_nettype wire
